// [shared/pdr_defs.svh]
// Offsets, field positions, reset values and timing counts for the sleep/power-up block
`ifndef PDR_DEFS_SVH
`define PDR_DEFS_SVH

// Register byte offsets
`define PDR_CTRL_OFF        8'h00
`define PDR_STATUS_OFF      8'h04
`define PDR_MC_OUT_OFF      8'h08
`define PDR_MC_OE_OFF       8'h0C
`define PDR_SLEW_OFF        8'h10
`define PDR_PIN_IN_OFF      8'h14
`define PDR_SIGNATURE_OFF   8'h18
`define PDR_DEVICE_ID_OFF   8'h1C
`define PDR_PATTERN_BASE    8'h40

// Control fields
`define PDR_CTRL_SLEEP_OPT  0
`define PDR_CTRL_FUSE_PROG  1

// Status fields
`define PDR_ST_ASLEEP       0
`define PDR_ST_POR_BUSY     1
`define PDR_ST_SECURED      2
`define PDR_ST_PIN_A        3
`define PDR_ST_PIN_B        4

// Macrocells tied to the two sleep request pins
`define PDR_MC_PIN_A        0
`define PDR_MC_PIN_B        1

// Reset values
`define PDR_OUT_POLARITY    16'h0000
`define PDR_SIGNATURE_RST   32'h0000_0000
// Arbitrary neutral identification value
`define PDR_DEVICE_ID       32'h0000_1234

// Power-up reset delay, time in ns and clock period
`define PDR_CLK_PERIOD_NS   100
`define PDR_T_D_NS          2000
`define PDR_T_D_CYCLES      ((`PDR_T_D_NS + `PDR_CLK_PERIOD_NS - 1) / `PDR_CLK_PERIOD_NS)

`endif

// [shared/pdr_pkg.sv]
// Types shared by the sleep/power-up block
package pdr_pkg;

   typedef enum logic [1:0]
   {
      PDR_BUS_IDLE,
      PDR_BUS_ACCESS,
      PDR_BUS_RESP
   } pdr_bus_state_t;

   typedef struct packed
   {
      logic [7:0] addr;
      logic       write;
   } pdr_bus_cmd_t;

   typedef struct packed
   {
      logic       pin_b;
      logic       pin_a;
      logic       secured;
      logic       por_busy;
      logic       asleep;
   } pdr_status_t;

endpackage : pdr_pkg

// [design/pdr_sync.sv]
// Two flip-flop synchroniser for pin inputs
module pdr_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_ff <= '0;
         q_ff    <= '0;
      end
      else
      begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end

   assign q_o = q_ff;
endmodule : pdr_sync

// [design/pdr_pattern_mem.sv]
// Configuration pattern store, 16 words, registered read
module pdr_pattern_mem (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // Write port
   input  wire logic        we_i,
   input  wire logic [3:0]  waddr_i,
   input  wire logic [31:0] wdata_i,
   // Read port
   input  wire logic [3:0]  raddr_i,
   output logic      [31:0] rdata_o
);
   logic [31:0] mem [16];
   logic [31:0] rdata_ff;

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         rdata_ff <= mem[raddr_i];
      end
   end

   assign rdata_o = rdata_ff;
endmodule : pdr_pattern_mem

// [design/pdr_top.sv]
// Pin-controlled sleep, power-up init, slew and pattern security, AHB-Lite slave
//
// Functional notes
// [R1] Sleep works only when option bit set
// [R2] Either sleep pin high enters sleep
// [R3] Sleep holds internal logic and enabled outputs
// [R4] Pin changes ignored until sleep pins low
// [R5] Sleep pins not logic inputs or outputs
// [R6] Sleep pin macrocells stay usable internally
// [R7] Outputs slow by default, fast per bit
// [R8] Power-up initializes registers, outputs by polarity
// [R9] Host meets setup before first clock high
// [R10] Host keeps clock still during reset delay; here the delay is counted in clock cycles and the bench clock keeps running
// [R11] Secured fuse blocks pattern read-back
// [R12] Signature and device id stay readable
// [R13] Wake resumes held state without reinit
`include "pdr_defs.svh"

module pdr_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Sleep request pins, shared with macrocells 0 and 1
   input  wire logic        sleep_request_pin_a_i,
   output logic             sleep_request_pin_a_o,
   output logic             sleep_request_pin_a_oe_o,
   input  wire logic        sleep_request_pin_b_i,
   output logic             sleep_request_pin_b_o,
   output logic             sleep_request_pin_b_oe_o,
   // Ordinary I/O pins, macrocells 2 to 15
   input  wire logic [13:0] io_i,
   output logic      [13:0] io_o,
   output logic      [13:0] io_oe_o,
   // Per-output edge rate, 1 = fast
   output logic      [15:0] slew_fast_o,
   // Sleep state
   output pdr_pkg::pdr_status_t status_o
);
   import pdr_pkg::*;

   localparam int unsigned TD_CYCLES = `PDR_T_D_CYCLES;

   function automatic logic pdr_in_pattern(input logic [7:0] a);
      pdr_in_pattern = (a[7:6] == 2'b01);
   endfunction : pdr_in_pattern

   // Synchronised pins
   logic [15:0]    pins_raw;
   logic [15:0]    pins_s;
   assign pins_raw = {io_i, sleep_request_pin_b_i, sleep_request_pin_a_i};

   pdr_sync #(.W(16)) u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .d_i     (pins_raw),
      .q_o     (pins_s)
   );

   // State
   pdr_bus_state_t bus_st_ff, nxt_bus_st;
   pdr_bus_cmd_t   cmd_ff, nxt_cmd;
   logic [31:0]    hrdata_ff, nxt_hrdata;
   logic           hreadyout_ff, nxt_hreadyout;
   logic           sleep_opt_ff, nxt_sleep_opt;
   logic           fuse_ff, nxt_fuse;
   logic           asleep_ff, nxt_asleep;
   logic [7:0]     por_cnt_ff, nxt_por_cnt;
   logic [15:0]    mc_out_ff, nxt_mc_out;
   logic [15:0]    mc_oe_ff, nxt_mc_oe;
   logic [15:0]    slew_ff, nxt_slew;
   logic [15:0]    pin_in_ff, nxt_pin_in;
   logic [31:0]    signature_ff, nxt_signature;
   logic [15:0]    pin_lvl_ff, nxt_pin_lvl;
   logic [15:0]    pin_oe_ff, nxt_pin_oe;
   pdr_status_t    status_ff, nxt_status;

   // Pattern memory hookup
   logic           mem_we;
   logic [31:0]    mem_rdata;

   pdr_pattern_mem u_mem (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .we_i    (mem_we),
      .waddr_i (cmd_ff.addr[5:2]),
      .wdata_i (hwdata_i),
      .raddr_i (cmd_ff.addr[5:2]),
      .rdata_o (mem_rdata)
   );

   logic        por_busy;
   logic        frozen;
   logic        wr_now;
   logic [15:0] pd_mask;
   logic [31:0] rd_mux;

   always_comb
   begin
      por_busy = (por_cnt_ff != 8'h00);
      // Hold applies from the cycle sleep is registered until both pins drop or the option bit clears
      frozen   = asleep_ff || por_busy; // [R3]
      wr_now   = (bus_st_ff == PDR_BUS_ACCESS) && cmd_ff.write;
      mem_we   = wr_now && pdr_in_pattern(cmd_ff.addr);
      pd_mask  = 16'h0000;
      if (sleep_opt_ff)
      begin
         pd_mask[`PDR_MC_PIN_A] = 1'b1; // [R5]
         pd_mask[`PDR_MC_PIN_B] = 1'b1; // [R5]
      end

      rd_mux = 32'h0000_0000;
      if (pdr_in_pattern(cmd_ff.addr))
      begin
         rd_mux = fuse_ff ? 32'h0000_0000 : mem_rdata; // [R11]
      end
      else
      begin
         unique case (cmd_ff.addr)
            `PDR_CTRL_OFF:      rd_mux = {{30{1'b0}}, fuse_ff, sleep_opt_ff};
            `PDR_STATUS_OFF:    rd_mux = {{27{1'b0}}, status_ff};
            `PDR_MC_OUT_OFF:    rd_mux = {16'h0000, mc_out_ff}; // [R6]
            `PDR_MC_OE_OFF:     rd_mux = {16'h0000, mc_oe_ff};
            `PDR_SLEW_OFF:      rd_mux = {16'h0000, slew_ff};
            `PDR_PIN_IN_OFF:    rd_mux = {16'h0000, pin_in_ff};
            `PDR_SIGNATURE_OFF: rd_mux = signature_ff; // [R12]
            `PDR_DEVICE_ID_OFF: rd_mux = `PDR_DEVICE_ID; // [R12]
            default:            rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_comb
   begin
      nxt_bus_st    = bus_st_ff;
      nxt_cmd       = cmd_ff;
      nxt_hrdata    = hrdata_ff;
      nxt_hreadyout = hreadyout_ff;
      nxt_sleep_opt = sleep_opt_ff;
      nxt_fuse      = fuse_ff;
      nxt_asleep    = asleep_ff;
      nxt_por_cnt   = por_cnt_ff;
      nxt_mc_out    = mc_out_ff;
      nxt_mc_oe     = mc_oe_ff;
      nxt_slew      = slew_ff;
      nxt_pin_in    = pin_in_ff;
      nxt_signature = signature_ff;
      nxt_pin_lvl   = pin_lvl_ff;
      nxt_pin_oe    = pin_oe_ff;

      // Power-up delay counts down once after reset
      if (por_busy)
      begin
         nxt_por_cnt = por_cnt_ff - 8'h01;
      end

      // Entry on either pin, exit when both are low again or when the option bit is cleared
      if (!sleep_opt_ff)
      begin
         nxt_asleep = 1'b0; // [R1]
      end
      else if (pins_s[`PDR_MC_PIN_A] || pins_s[`PDR_MC_PIN_B])
      begin
         nxt_asleep = 1'b1; // [R2] [R4]
      end
      else
      begin
         nxt_asleep = 1'b0; // [R13]
      end

      // Input capture; sleep pins never feed logic when the option is on
      if (!frozen)
      begin
         nxt_pin_in = pins_s & ~pd_mask; // [R4] [R5]
      end

      // Bus slave: two wait cycles, answer always OKAY
      unique case (bus_st_ff)
         PDR_BUS_IDLE:
         begin
            if (hsel_i && htrans_i[1] && hready_i)
            begin
               nxt_cmd.addr  = haddr_i[7:0];
               nxt_cmd.write = hwrite_i;
               nxt_hreadyout = 1'b0;
               nxt_bus_st    = PDR_BUS_ACCESS;
            end
         end
         PDR_BUS_ACCESS:
         begin
            nxt_bus_st = PDR_BUS_RESP;
            if (wr_now)
            begin
               unique case (cmd_ff.addr)
                  `PDR_CTRL_OFF:
                  begin
                     nxt_sleep_opt = hwdata_i[`PDR_CTRL_SLEEP_OPT];
                     // Fuse is one-way; only power-up clears it
                     nxt_fuse      = fuse_ff | hwdata_i[`PDR_CTRL_FUSE_PROG];
                  end
                  `PDR_MC_OUT_OFF:
                  begin
                     if (!frozen)
                     begin
                        nxt_mc_out = hwdata_i[15:0]; // [R3] [R6]
                     end
                  end
                  `PDR_MC_OE_OFF:
                  begin
                     if (!frozen)
                     begin
                        nxt_mc_oe = hwdata_i[15:0]; // [R3]
                     end
                  end
                  `PDR_SLEW_OFF:      nxt_slew      = hwdata_i[15:0]; // [R7]
                  `PDR_SIGNATURE_OFF: nxt_signature = hwdata_i;
                  default:            nxt_slew      = slew_ff;
               endcase
            end
         end
         PDR_BUS_RESP:
         begin
            nxt_hrdata    = cmd_ff.write ? 32'h0000_0000 : rd_mux;
            nxt_hreadyout = 1'b1;
            nxt_bus_st    = PDR_BUS_IDLE;
         end
      endcase

      // Pin drivers follow logic unless held
      if (!frozen)
      begin
         nxt_pin_lvl = mc_out_ff ^ `PDR_OUT_POLARITY; // [R8]
         nxt_pin_oe  = mc_oe_ff & ~pd_mask; // [R5]
      end
      else if (asleep_ff)
      begin
         nxt_pin_lvl = pin_lvl_ff; // [R3]
         nxt_pin_oe  = pin_oe_ff; // [R3]
      end

      nxt_status.asleep   = nxt_asleep;
      nxt_status.por_busy = (nxt_por_cnt != 8'h00);
      nxt_status.secured  = nxt_fuse;
      nxt_status.pin_a    = pins_s[`PDR_MC_PIN_A];
      nxt_status.pin_b    = pins_s[`PDR_MC_PIN_B];
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         bus_st_ff    <= PDR_BUS_IDLE;
         cmd_ff       <= '0;
         hrdata_ff    <= 32'h0000_0000;
         hreadyout_ff <= 1'b1;
         sleep_opt_ff <= 1'b0;
         fuse_ff      <= 1'b0;
         asleep_ff    <= 1'b0;
         por_cnt_ff   <= 8'(TD_CYCLES); // [R8] [R10]
         mc_out_ff    <= 16'h0000; // [R8]
         mc_oe_ff     <= 16'h0000;
         slew_ff      <= 16'h0000; // [R7]
         pin_in_ff    <= 16'h0000;
         signature_ff <= `PDR_SIGNATURE_RST;
         pin_lvl_ff   <= `PDR_OUT_POLARITY; // [R8]
         pin_oe_ff    <= 16'h0000;
         status_ff    <= '0;
      end
      else
      begin
         bus_st_ff    <= nxt_bus_st;
         cmd_ff       <= nxt_cmd;
         hrdata_ff    <= nxt_hrdata;
         hreadyout_ff <= nxt_hreadyout;
         sleep_opt_ff <= nxt_sleep_opt;
         fuse_ff      <= nxt_fuse;
         asleep_ff    <= nxt_asleep;
         por_cnt_ff   <= nxt_por_cnt;
         mc_out_ff    <= nxt_mc_out;
         mc_oe_ff     <= nxt_mc_oe;
         slew_ff      <= nxt_slew;
         pin_in_ff    <= nxt_pin_in;
         signature_ff <= nxt_signature;
         pin_lvl_ff   <= nxt_pin_lvl;
         pin_oe_ff    <= nxt_pin_oe;
         status_ff    <= nxt_status;
      end
   end

   assign hrdata_o                 = hrdata_ff;
   assign hreadyout_o              = hreadyout_ff;
   assign hresp_o                  = 1'b0;
   assign sleep_request_pin_a_o    = pin_lvl_ff[`PDR_MC_PIN_A];
   assign sleep_request_pin_a_oe_o = pin_oe_ff[`PDR_MC_PIN_A];
   assign sleep_request_pin_b_o    = pin_lvl_ff[`PDR_MC_PIN_B];
   assign sleep_request_pin_b_oe_o = pin_oe_ff[`PDR_MC_PIN_B];
   assign io_o                     = pin_lvl_ff[15:2];
   assign io_oe_o                  = pin_oe_ff[15:2];
   assign slew_fast_o              = slew_ff;
   assign status_o                 = status_ff;
endmodule : pdr_top

// [verification/pdr_top_sva.sv]
// Port-level assertions for pdr_top
module pdr_top_sva (
   // Clock and reset
   input wire logic                 clk_i,
   input wire logic                 reset_i,
   // Bus
   input wire logic                 hsel_i,
   input wire logic [1:0]           htrans_i,
   input wire logic                 hready_i,
   input wire logic                 hreadyout_o,
   input wire logic                 hresp_o,
   // Pins
   input wire logic                 sleep_request_pin_a_i,
   input wire logic                 sleep_request_pin_b_i,
   input wire logic                 sleep_request_pin_a_oe_o,
   input wire logic                 sleep_request_pin_b_oe_o,
   input wire logic [13:0]          io_o,
   input wire logic [13:0]          io_oe_o,
   input wire logic [15:0]          slew_fast_o,
   input wire pdr_pkg::pdr_status_t status_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import pdr_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_bus_wait: assert property (hsel_i && htrans_i[1] && hready_i && hreadyout_o
      |=> !hreadyout_o [*2] ##1 hreadyout_o) else $error("bus wait not two cycles");
   a_resp_okay: assert property (hresp_o == 1'b0) else $error("response not okay");
   a_reset_quiet: assert property ($fell(reset_i) |-> slew_fast_o == 16'h0000
      && io_oe_o == 14'h0000) else $error("outputs not initialized");
   a_por_frozen: assert property (status_o.por_busy && $past(status_o.por_busy)
      |-> $stable(io_o) && $stable(io_oe_o)) else $error("outputs moved in power-up");
   a_sleep_hold: assert property (status_o.asleep && $past(status_o.asleep)
      |-> $stable(io_o) && $stable(io_oe_o)) else $error("outputs moved while asleep");
   a_pins_off: assert property (status_o.asleep
      |-> !sleep_request_pin_a_oe_o && !sleep_request_pin_b_oe_o) else $error("pin driven");
   // Two sync stages and the sleep register: the deciding pin sample is three back
   a_sleep_entry: assert property ($rose(status_o.asleep)
      |-> $past(sleep_request_pin_a_i, 3) || $past(sleep_request_pin_b_i, 3))
      else $error("sleep without request");
   a_sleep_exit: assert property ($fell(status_o.asleep)
      |-> !$past(sleep_request_pin_a_i, 3) && !$past(sleep_request_pin_b_i, 3))
      else $error("wake while request high");
   a_wake_resume: assert property ($fell(status_o.asleep)
      |-> $stable(io_o) && $stable(io_oe_o)) else $error("outputs moved on wake");

   c_sleep: cover property ($rose(status_o.asleep));
   c_bus: cover property (hsel_i && htrans_i[1] && hready_i && hreadyout_o);
   c_secured: cover property ($rose(status_o.secured));
   c_wake: cover property ($fell(status_o.asleep));
endmodule : pdr_top_sva

// [verification/pdr_host_model.sv]
// Host-side model driving the sleep request pins and the plain inputs
`include "pdr_defs.svh"
module pdr_host_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // Requests from the bench
   input  wire logic        want_a_i,
   input  wire logic        want_b_i,
   input  wire logic [13:0] want_io_i,
   // Pin levels
   output logic             pin_a_o,
   output logic             pin_b_o,
   output logic      [13:0] io_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int settle;
   // Nothing moves until the power-up delay is over, so setup is met
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         settle  <= 0;
         pin_a_o <= 1'b0;
         pin_b_o <= 1'b0;
         io_o    <= 14'h0000;
      end
      else if (settle < `PDR_T_D_CYCLES + 2)
         settle <= settle + 1;
      else
      begin
         pin_a_o <= want_a_i;
         pin_b_o <= want_b_i;
         io_o    <= want_io_i;
      end
   end
endmodule : pdr_host_model

// [verification/tb_top.sv]
// Self-checking bench for pdr_top
`include "pdr_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pdr_pkg::*;
   typedef struct {string nm; logic [31:0] ex; int src;} pdr_note_t;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        hsel_i = 1'b0, hwrite_i = 1'b0, rd_ph = 1'b0, probe = 1'b0;
   logic        want_a = 1'b0, want_b = 1'b0;
   logic [1:0]  htrans_i = 2'h0;
   logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, hrdata_o;
   logic        hreadyout_o, hresp_o, pa_oe, pb_oe, pa_o, pb_o, pa_w, pb_w, host_a, host_b;
   logic [13:0] io_o, io_oe_o, io_w, host_io, want_io = 14'h0000;
   logic [15:0] slew_fast_o;
   logic [31:0] v, sg, oe, mo, hv, pin;
   pdr_status_t status_o;
   pdr_note_t   notes[$];
   pdr_note_t   cur;
   int          miscompares = 0, comparisons = 0, seed = 21795;

   always #50 clk_i = ~clk_i;
   assign pa_w = pa_oe ? pa_o : host_a;
   assign pb_w = pb_oe ? pb_o : host_b;
   assign io_w = (io_oe_o & io_o) | (~io_oe_o & host_io);

   pdr_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o), .sleep_request_pin_a_i(pa_w), .sleep_request_pin_a_o(pa_o),
      .sleep_request_pin_a_oe_o(pa_oe), .sleep_request_pin_b_i(pb_w),
      .sleep_request_pin_b_o(pb_o), .sleep_request_pin_b_oe_o(pb_oe), .io_i(io_w),
      .io_o(io_o), .io_oe_o(io_oe_o), .slew_fast_o(slew_fast_o), .status_o(status_o));
   pdr_host_model host_u (.clk_i(clk_i), .reset_i(reset_i), .want_a_i(want_a),
      .want_b_i(want_b), .want_io_i(want_io), .pin_a_o(host_a), .pin_b_o(host_b),
      .io_o(host_io));

   function automatic logic [31:0] seen(int s);
      case (s)
         0: return hrdata_o;
         1: return {16'h0000, slew_fast_o};
         2: return {4'h0, io_oe_o, io_o};
         3: return {30'h0, pb_oe, pa_oe};
         default: return {27'h0, status_o};
      endcase
   endfunction : seen

   function automatic logic [13:0] iox();
      return (oe[15:2] & mo[15:2]) | (~oe[15:2] & hv[13:0]);
   endfunction : iox

   // Results are compared in the order the driver noted them
   always @(posedge clk_i)
   begin
      if (((rd_ph && hreadyout_o) || probe) && notes.size() > 0)
      begin
         cur = notes.pop_front();
         comparisons++;
         if (seen(cur.src) !== cur.ex)
         begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", cur.nm, cur.ex, seen(cur.src));
         end
      end
   end

   task automatic tally_and_finish();
      // A note never answered is a result that did not appear
      miscompares += notes.size();
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic wait_rdy();
      int k;
      k = 0;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1 && k < 50)
      begin
         @(posedge clk_i);
         k++;
      end
      if (hreadyout_o !== 1'b1)
      begin
         miscompares++;
         tally_and_finish();
      end
   endtask : wait_rdy

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input string nm);
      haddr_i  <= a;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      hsel_i   <= 1'b1;
      wait_rdy();
      htrans_i <= 2'h0;
      hwdata_i <= d;
      rd_ph    <= !w;
      if (!w)
         notes.push_back('{nm, d, 0});
      wait_rdy();
      rd_ph <= 1'b0;
   endtask : bus

   task automatic probe_port(input int s, input logic [31:0] e, input string nm);
      notes.push_back('{nm, e, s});
      probe <= 1'b1;
      @(posedge clk_i);
      probe <= 1'b0;
      @(posedge clk_i);
   endtask : probe_port

   initial
   begin
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      probe_port(4, 32'h0000_0002, "por_busy");
      probe_port(1, 32'h0000_0000, "slew_reset");
      probe_port(3, 32'h0000_0000, "pin_oe_reset");
      repeat (25) @(posedge clk_i);
      probe_port(4, 32'h0000_0000, "por_done");
      $display("test reset done");
      sg = $random(seed);
      bus(1'b0, `PDR_DEVICE_ID_OFF, `PDR_DEVICE_ID, "device_id");
      bus(1'b1, `PDR_SIGNATURE_OFF, sg, "");
      bus(1'b0, `PDR_SIGNATURE_OFF, sg, "signature");
      bus(1'b1, 32'h0000_0030, sg, "");
      bus(1'b0, 32'h0000_0030, 32'h0000_0000, "unmapped");
      v = $random(seed);
      bus(1'b1, `PDR_SLEW_OFF, v, "");
      bus(1'b0, `PDR_SLEW_OFF, {16'h0000, v[15:0]}, "slew_reg");
      probe_port(1, {16'h0000, v[15:0]}, "slew_pins");
      $display("test registers done");
      mo = $random(seed) & 32'h0000_FFFF;
      oe = $random(seed) & 32'h0000_FFFC;
      hv = $random(seed);
      want_io <= hv[13:0];
      want_a  <= 1'b1;
      bus(1'b1, `PDR_MC_OUT_OFF, mo, "");
      bus(1'b1, `PDR_MC_OE_OFF, oe, "");
      bus(1'b0, `PDR_MC_OE_OFF, oe, "mc_oe_reg");
      repeat (8) @(posedge clk_i);
      probe_port(2, {4'h0, oe[15:2], mo[15:2]}, "io_drive");
      // Pin a is an ordinary input here, so status shows it high without sleep
      probe_port(4, 32'h0000_0008, "no_option");
      bus(1'b0, `PDR_PIN_IN_OFF, {16'h0000, iox(), 2'b01}, "pin_plain");
      want_a <= 1'b0;
      repeat (8) @(posedge clk_i);
      bus(1'b1, `PDR_CTRL_OFF, 32'h0000_0001, "");
      $display("test option off done");
      for (int i = 0; i < 2; i++)
      begin
         pin = {16'h0000, iox(), 2'b00};
         want_a <= (i == 0);
         want_b <= (i == 1);
         repeat (8) @(posedge clk_i);
         probe_port(4, (i == 0) ? 32'h0000_0009 : 32'h0000_0011, "asleep");
         probe_port(3, 32'h0000_0000, "pin_oe_sleep");
         hv = $random(seed);
         want_io <= hv[13:0];
         bus(1'b1, `PDR_MC_OUT_OFF, ~mo, "");
         repeat (4) @(posedge clk_i);
         probe_port(2, {4'h0, oe[15:2], mo[15:2]}, "io_held");
         bus(1'b0, `PDR_PIN_IN_OFF, pin, "pin_held");
         want_a <= 1'b0;
         want_b <= 1'b0;
         repeat (8) @(posedge clk_i);
         probe_port(4, 32'h0000_0000, "awake");
         probe_port(2, {4'h0, oe[15:2], mo[15:2]}, "io_resume");
         bus(1'b0, `PDR_MC_OUT_OFF, mo, "mc_out_kept");
         $display("test sleep %0d done", i);
      end
      mo = 32'h0000_0003;
      bus(1'b1, `PDR_MC_OUT_OFF, mo, "");
      bus(1'b0, `PDR_MC_OUT_OFF, mo, "mc_out_sleep_cells");
      repeat (4) @(posedge clk_i);
      bus(1'b0, `PDR_PIN_IN_OFF, {16'h0000, iox(), 2'b00}, "pin_resampled");
      v = $random(seed);
      bus(1'b1, `PDR_PATTERN_BASE + 8'h04, v, "");
      bus(1'b0, `PDR_PATTERN_BASE + 8'h04, v, "pattern");
      bus(1'b1, `PDR_CTRL_OFF, 32'h0000_0003, "");
      bus(1'b0, `PDR_PATTERN_BASE + 8'h04, 32'h0000_0000, "pattern_secured");
      probe_port(4, 32'h0000_0004, "secured");
      bus(1'b0, `PDR_CTRL_OFF, 32'h0000_0003, "ctrl_fuse");
      bus(1'b0, `PDR_STATUS_OFF, 32'h0000_0004, "status_reg");
      bus(1'b0, `PDR_DEVICE_ID_OFF, `PDR_DEVICE_ID, "device_id_secured");
      bus(1'b0, `PDR_SIGNATURE_OFF, sg, "signature_secured");
      $display("test security done");
      repeat (2) @(posedge clk_i);
      tally_and_finish();
   end
endmodule : tb_top

bind pdr_top pdr_top_sva chk_u (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .sleep_request_pin_a_i(sleep_request_pin_a_i), .sleep_request_pin_b_i(sleep_request_pin_b_i),
   .sleep_request_pin_a_oe_o(sleep_request_pin_a_oe_o),
   .sleep_request_pin_b_oe_o(sleep_request_pin_b_oe_o), .io_o(io_o), .io_oe_o(io_oe_o),
   .slew_fast_o(slew_fast_o), .status_o(status_o));
